// *** rtl/spi_chain_pkg.sv ***
// constants and types shared by the serial chain front end
package spi_chain_pkg;
  localparam int unsigned CORE_CLK_MHZ = 100;
  // interface setup time after enable, in microseconds
  localparam int unsigned SETUP_TIME_US = 150;
  localparam int unsigned SETUP_CYCLES = SETUP_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FRAME_MIN_BITS = 24;
  // address byte layout
  localparam int unsigned ADDR_MARK_POS = 7;
  localparam int unsigned ADDR_TOKEN_POS = 6;
  localparam int unsigned ADDR_ACCESS_POS = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {
    ph_own_addr,
    ph_pass,
    ph_data
  } frame_phase_t;
endpackage : spi_chain_pkg

// *** rtl/spi_sync_if.sv ***
// synchronised link pins and edge strobes between the two modules
`timescale 1ns/100ps
`default_nettype none
interface spi_sync_if;
  logic sel;
  logic sel_fall;
  logic sel_rise;
  logic clk_rise;
  logic clk_fall;
  logic clk_level;
  logic din;
  modport source (output sel, sel_fall, sel_rise, clk_rise, clk_fall,
    clk_level, din);
  modport sink (input sel, sel_fall, sel_rise, clk_rise, clk_fall,
    clk_level, din);
endinterface : spi_sync_if
`default_nettype wire

// *** rtl/spi_pin_sync.sv ***
// two-flop synchronisers and edge finders for the serial pins
`timescale 1ns/100ps
`default_nettype none
module spi_pin_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  spi_sync_if.source sync
);
  logic [1:0] sclk_meta;
  logic [1:0] cs_meta;
  logic [1:0] sdi_meta;
  logic sclk_last;
  logic cs_last;

  // first stage is read only by the second; chip select idles high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_meta <= 2'h0;
      cs_meta <= 2'h3;
      sdi_meta <= 2'h0;
      sclk_last <= 1'b0;
      cs_last <= 1'b1;
    end else begin
      sclk_meta <= {sclk_meta[0], sclk};
      cs_meta <= {cs_meta[0], cs_b};
      sdi_meta <= {sdi_meta[0], sdi};
      sclk_last <= sclk_meta[1];
      cs_last <= cs_meta[1];
    end
  end

  // edge strobes from the settled stage only
  assign sync.sel = ~cs_meta[1];
  assign sync.sel_fall = cs_last & ~cs_meta[1];
  assign sync.sel_rise = ~cs_last & cs_meta[1];
  assign sync.clk_rise = ~sclk_last & sclk_meta[1];
  assign sync.clk_fall = sclk_last & ~sclk_meta[1];
  assign sync.clk_level = sclk_meta[1];
  assign sync.din = sdi_meta[1];
endmodule : spi_pin_sync
`default_nettype wire

// *** rtl/spi_slave_daisy_chain.sv ***
// serial slave with daisy-chain framing, error flag and startup delay
`timescale 1ns/100ps
`default_nettype none
module spi_slave_daisy_chain
  import spi_chain_pkg::*;
#(
  parameter int unsigned SETUP_COUNT = SETUP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_b,
  input wire logic fail_safe,
  input wire logic [6:0] status_bits,
  input wire logic pwm_overlap_error,
  input wire logic frame_fault,
  input wire logic [15:0] response_word,
  output logic interface_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_address,
  output logic [15:0] cmd_data,
  output logic protocol_error_flag,
  output logic global_error_indication
);
  spi_sync_if sync ();
  logic en_meta;
  logic en_sync;
  logic [$clog2(SETUP_COUNT+1)-1:0] setup_count;
  frame_phase_t phase;
  logic [7:0] own_addr;
  logic [15:0] shifter;
  logic [5:0] bit_count;
  logic bit_total_ok;
  logic saw_last;
  logic err_pending;
  logic fs_latched;
  logic pwm_last;
  logic [7:0] status_byte;

  spi_pin_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .cs_b(cs_b),
    .sdi(sdi),
    .sync(sync)
  );

  // *****************************************************
  // startup delay
  // *****************************************************
  // counter runs after enable rises; link is ignored until done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      setup_count <= '0;
      interface_ready <= 1'b0;
    end else begin
      en_meta <= enable;
      en_sync <= en_meta;
      if (!en_sync) begin
        setup_count <= '0;
        interface_ready <= 1'b0;
      end else if (setup_count < ($bits(setup_count))'(SETUP_COUNT)) begin
        setup_count <= setup_count + 1'b1;
      end else begin
        interface_ready <= 1'b1;
      end
    end
  end

  // *****************************************************
  // frame engine
  // *****************************************************
  function automatic logic is_address(input logic [7:0] b);
    return b[ADDR_MARK_POS];
  endfunction : is_address

  logic [7:0] next_byte;
  assign next_byte = {shifter[6:0], sync.din};

  // sample on rising link clock, byte phases per position
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= ph_own_addr;
      own_addr <= 8'h00;
      shifter <= 16'h0000;
      bit_count <= 6'h00;
      bit_total_ok <= 1'b1;
      saw_last <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_address <= 8'h00;
      cmd_data <= 16'h0000;
      err_pending <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (sync.sel_fall && interface_ready) begin
        phase <= ph_own_addr;
        bit_count <= 6'h00;
        bit_total_ok <= 1'b1;
        saw_last <= 1'b0;
        err_pending <= 1'b0;
        // status goes out first, behind the indication bit
        shifter <= {status_byte, 8'h00};
      end else if (sync.sel && interface_ready && sync.clk_rise) begin
        bit_count <= (bit_count == 6'd7) ? 6'h00 : bit_count + 1'b1;
        bit_total_ok <= (bit_count == 6'd7);
        unique case (phase)
          ph_own_addr: begin
            shifter <= {shifter[14:0], sync.din};
            if (bit_count == 6'd7) begin
              if (is_address(next_byte)) begin
                own_addr <= next_byte;
                phase <= next_byte[ADDR_TOKEN_POS] ? ph_data : ph_pass;
                saw_last <= next_byte[ADDR_TOKEN_POS];
                if (next_byte[ADDR_TOKEN_POS]) begin
                  shifter <= response_word;
                end
              end else begin
                err_pending <= 1'b1;
              end
            end
          end
          ph_pass: begin
            shifter <= {shifter[14:0], sync.din};
            if (bit_count == 6'd7) begin
              if (!is_address(next_byte)) begin
                err_pending <= 1'b1; // gap between address bytes
              end else if (next_byte[ADDR_TOKEN_POS]) begin
                phase <= ph_data;
                saw_last <= 1'b1;
                shifter <= response_word;
              end
            end
          end
          ph_data: begin
            shifter <= {shifter[14:0], sync.din};
          end
          default: phase <= ph_own_addr;
        endcase
      end else if (sync.sel_rise && interface_ready) begin
        // partial byte or missing token is a frame error
        if (!bit_total_ok || !saw_last || err_pending ||
            bit_count != 6'h00 || frame_fault) begin
          err_pending <= 1'b1;
        end else begin
          cmd_valid <= 1'b1;
          cmd_address <= own_addr;
          cmd_data <= shifter;
        end
      end
    end
  end

  // *****************************************************
  // protocol error flag
  // *****************************************************
  // the event wins over any clear that lands in the same cycle
  logic frame_end_bad;
  logic frame_end_good;
  assign frame_end_bad = sync.sel_rise && interface_ready &&
    (!bit_total_ok || !saw_last || err_pending || bit_count != 6'h00 ||
     frame_fault);
  assign frame_end_good = sync.sel_rise && interface_ready && !frame_end_bad;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      protocol_error_flag <= 1'b0;
      fs_latched <= 1'b0;
      pwm_last <= 1'b0;
    end else begin
      pwm_last <= pwm_overlap_error;
      if (frame_end_bad || pwm_overlap_error) begin
        protocol_error_flag <= 1'b1;
        fs_latched <= fail_safe;
      end else if (fs_latched) begin
        if (!fail_safe) begin
          fs_latched <= 1'b0;
        end
      end else if (pwm_last && !fail_safe) begin
        // overlap cause goes away when the master clears its status
        protocol_error_flag <= 1'b0;
      end else if (frame_end_good && !fail_safe) begin
        protocol_error_flag <= 1'b0;
      end
    end
  end

  // *****************************************************
  // serial output
  // *****************************************************
  assign status_byte = {status_bits[6:1], ~status_bits[0] ^ 1'b1,
    protocol_error_flag};
  assign global_error_indication = (|status_bits) | protocol_error_flag;

  // output moves on falling link clock; indication before first rise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo <= 1'b0;
      sdo_oe_b <= 1'b1;
    end else begin
      if (!sync.sel || !interface_ready) begin
        sdo_oe_b <= 1'b1;
        sdo <= 1'b0;
      end else if (sync.sel_fall) begin
        sdo_oe_b <= 1'b0;
        sdo <= global_error_indication | sync.din;
      end else if (err_pending && phase != ph_data) begin
        sdo <= 1'b0; // blocks later devices on gaps
      end else if (sync.clk_fall) begin
        if (phase == ph_pass) begin
          sdo <= sync.din;
        end else begin
          sdo <= shifter[15];
        end
      end
    end
  end

  // *****************************************************
  // checks
  // *****************************************************
  property p_ind_on_select;
    @(posedge core_clk) disable iff (!rst_b)
    (sync.sel_fall && interface_ready) |=> (!sdo_oe_b &&
      (sdo == ($past(global_error_indication) | $past(sync.din))));
  endproperty
  a_ind_on_select: assert property (p_ind_on_select)
    else $error("indication not shown after select fell");

  property p_flag_set;
    @(posedge core_clk) disable iff (!rst_b)
    frame_end_bad |=> protocol_error_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("frame error did not raise flag");

  property p_fs_hold;
    @(posedge core_clk) disable iff (!rst_b)
    (protocol_error_flag && fs_latched && fail_safe) |=> protocol_error_flag;
  endproperty
  a_fs_hold: assert property (p_fs_hold)
    else $error("flag cleared during fail safe");

  property p_good_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (frame_end_good && !fs_latched && !fail_safe && !pwm_overlap_error)
      |=> !protocol_error_flag;
  endproperty
  a_good_clear: assert property (p_good_clear)
    else $error("good frame did not clear flag");

  property p_pwm_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (pwm_last && !pwm_overlap_error && !frame_end_bad && !fs_latched &&
      !fail_safe) |=> !protocol_error_flag;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear)
    else $error("overlap clear did not clear flag");

  property p_cmd_pulse;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_valid |=> !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command strobe longer than one cycle");

  property p_idle_hiz;
    @(posedge core_clk) disable iff (!rst_b)
    !sync.sel |=> sdo_oe_b;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("output driven outside frame");

  property p_not_ready;
    @(posedge core_clk) disable iff (!rst_b)
    !en_sync |=> !interface_ready;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("ready without enable");

  property p_load_resp;
    @(posedge core_clk) disable iff (!rst_b)
    (phase != ph_data) ##1 (phase == ph_data) |-> shifter == $past(response_word);
  endproperty
  a_load_resp: assert property (p_load_resp)
    else $error("response not loaded at last token");
endmodule : spi_slave_daisy_chain
`default_nettype wire

// *** tb/spi_master_model.sv ***
// serial master model driving the link pins of the slave
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  input wire logic core_clk,
  output logic sclk,
  output logic cs_b,
  output logic sdi,
  input wire logic sdo
);
  logic [63:0] rx;
  logic lead;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end
  // one frame, msb first; 80 ns link period, clock still between frames
  task automatic frame(input logic [63:0] tx, input int nbits);
    @(negedge core_clk);
    cs_b = 1'b0;
    repeat (25) @(negedge core_clk);
    lead = sdo;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (4) @(negedge core_clk);
      rx = {rx[62:0], sdo};
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (25) @(negedge core_clk);
    cs_b = 1'b1;
    // released data line settles to its pull-down level, not its last bit
    sdi = 1'b0;
    repeat (300) @(negedge core_clk);
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

// *** tb/test_spi_slave_daisy_chain.sv ***
// self-checking bench for the serial chain slave
`timescale 1ns/100ps
`default_nettype none
module test_spi_slave_daisy_chain;
  import spi_chain_pkg::*;
  localparam int unsigned SETUP_TEST = 20;
  logic core_clk = 1'b0;
  logic rst_b, enable, sclk, cs_b, sdi, sdo, sdo_oe_b;
  logic fail_safe, pwm_overlap_error, interface_ready, cmd_valid;
  logic protocol_error_flag, global_error_indication, mflag;
  logic [6:0] status_bits;
  logic [15:0] response_word, cmd_data;
  logic [7:0] cmd_address;
  logic [63:0] tx;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 16;
  int cycles = 0;
  int valid_count = 0;
  always #5 core_clk = ~core_clk;
  spi_slave_daisy_chain #(.SETUP_COUNT(SETUP_TEST)) spi_slave_daisy_chain_i (
    .core_clk(core_clk), .rst_b(rst_b), .enable(enable), .sclk(sclk),
    .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe_b(sdo_oe_b),
    .fail_safe(fail_safe), .status_bits(status_bits),
    .pwm_overlap_error(pwm_overlap_error), .frame_fault(1'b0),
    .response_word(response_word), .interface_ready(interface_ready),
    .cmd_valid(cmd_valid), .cmd_address(cmd_address), .cmd_data(cmd_data),
    .protocol_error_flag(protocol_error_flag),
    .global_error_indication(global_error_indication));
  spi_master_model spi_master_model_i (.core_clk(core_clk), .sclk(sclk),
    .cs_b(cs_b), .sdi(sdi), .sdo(sdo));
  // ****************************************
  // comparison, verdict, watchdogs
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] expected);
    total_checks++;
    if (seen !== expected) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen,
        expected);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // pulse counter and hang limit, about seven times the expected run
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1) valid_count++;
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  // one frame plus the reference model of flag, response and command
  task automatic run(input logic [63:0] t, input int nbits);
    int tok;
    int v0;
    logic good;
    logic lead_exp;
    @(negedge core_clk);
    status_bits = 7'($random(seed));
    response_word = 16'($random(seed));
    good = (nbits % 8 == 0) && (nbits >= 24);
    tok = 0;
    while (tok < nbits / 8 - 1 && !t[nbits - 2 - 8 * tok]) tok++;
    lead_exp = (|status_bits) | mflag;
    v0 = valid_count;
    spi_master_model_i.frame(t, nbits);
    if (!good || pwm_overlap_error) mflag = 1'b1;
    else if (!fail_safe) mflag = 1'b0;
    check(spi_master_model_i.lead, lead_exp);
    check(protocol_error_flag, mflag);
    check(sdo_oe_b, 1'b1);
    check(global_error_indication, (|status_bits) | mflag);
    if (good) begin
      check((spi_master_model_i.rx >> (nbits - 8 * tok - 24)) & 64'hFFFF,
        response_word);
    end
    if (!good) check(64'(valid_count - v0), 64'h0);
    if (good && !fail_safe && !pwm_overlap_error) begin
      check(64'(valid_count - v0), 64'h1);
      check(cmd_address, t[nbits - 1 -: 8]);
      check(cmd_data, t[15:0]);
    end
  endtask : run
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    enable = 1'b0;
    fail_safe = 1'b0;
    pwm_overlap_error = 1'b0;
    status_bits = 7'h00;
    response_word = 16'h0000;
    mflag = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    enable = 1'b1;
    repeat (10) @(negedge core_clk);
    check(interface_ready, 1'b0);
    repeat (SETUP_TEST + 5) @(negedge core_clk);
    check(interface_ready, 1'b1);
    // one to four address bytes, token only in the last
    for (int n = 1; n <= 4; n++) begin
      tx = 64'h0;
      for (int i = 0; i < n; i++) begin
        tx = {tx[55:0], 8'h80 | (i == n - 1 ? 8'h40 : 8'h00) |
          (8'($random(seed)) & 8'h3F)};
      end
      tx = {tx[47:0], 16'($random(seed))};
      run(tx, 8 * n + 16);
    end
    run(64'h00000000000C1234, 20);
    run(64'h0000000000C1BEEF, 24);
    fail_safe = 1'b1;
    run(64'h00000000000C1234, 20);
    run(64'h0000000000C15A5A, 24);
    fail_safe = 1'b0;
    run(64'h0000000000C1A5A5, 24);
    pwm_overlap_error = 1'b1;
    run(64'h0000000000C10F0F, 24);
    pwm_overlap_error = 1'b0;
    repeat (5) @(negedge core_clk);
    mflag = 1'b0;
    check(protocol_error_flag, 1'b0);
    wrap_up();
  end
endmodule : test_spi_slave_daisy_chain
`default_nettype wire
